// [adc_cfg_pkg.sv]
package adc_cfg_pkg;
	localparam logic [3:0] ADDR_CFG_A = 4'h2;
	localparam logic [3:0] ADDR_CFG_B = 4'h3;
	localparam logic [7:0] RST_CFG_A  = 8'h0c;
	localparam logic [7:0] RST_CFG_B  = 8'h8b;
	localparam int PRE_HI = 7;
	localparam int PRE_LO = 6;
	localparam int OSR_HI = 5;
	localparam int OSR_LO = 2;
	localparam int BIAS_HI = 7;
	localparam int BIAS_LO = 6;
	localparam int GAIN_HI = 5;
	localparam int GAIN_LO = 3;
	localparam int AZ_IN_BIT = 2;
	localparam int REFERENCE_CHOP_ENABLE_BIT = 1;
	localparam logic [1:0] RSV_A_VAL = 2'h0;
	localparam logic       RSV_B_VAL = 1'h1;
	localparam logic [2:0] GAIN_X64 = 3'h7;
	localparam logic [2:0] GAIN_X32 = 3'h6;
	localparam logic [1:0] DGAIN_X1 = 2'h0;
	localparam logic [1:0] DGAIN_X2 = 2'h1;
	localparam logic [1:0] DGAIN_X4 = 2'h2;
endpackage

// [adc_conversion_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_config_regs
(
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_sys_rst,
	// Register port
	input  wire logic [3:0] i_reg_addr,
	input  wire logic       i_reg_wr,
	input  wire logic [7:0] i_reg_wdata,
	output logic      [7:0] o_reg_rdata,
	// Context from other configuration
	input  wire logic       i_ref_internal_sel,
	input  wire logic       i_continuous_req,
	// Exported settings
	output logic      [1:0] o_analog_clk_div_log2,
	output logic      [3:0] o_oversampling_ratio,
	output logic      [1:0] o_bias_current_select,
	output logic      [2:0] o_analog_gain_code,
	output logic      [1:0] o_digital_gain_shift,
	output logic            o_input_autozero_enable,
	output logic            o_reference_chop_active,
	output logic            o_conv_time_double,
	output logic            o_single_shot_chain
);
	logic [7:0] cfg_a_r;
	logic [7:0] cfg_b_r;
	logic [7:0] rdata_nxt;
	wire        sel_a = (i_reg_addr == adc_cfg_pkg::ADDR_CFG_A);
	wire        sel_b = (i_reg_addr == adc_cfg_pkg::ADDR_CFG_B);
	wire  [2:0] gain_w = cfg_b_r[adc_cfg_pkg::GAIN_HI:adc_cfg_pkg::GAIN_LO];
	wire        az_in_w = cfg_b_r[adc_cfg_pkg::AZ_IN_BIT];
	wire  [2:0] again_w;
	wire  [1:0] dgain_w;
	wire        chop_w;

	// Gain split: codes above 3'h5 (x16) add digital shift
	assign again_w = (gain_w == adc_cfg_pkg::GAIN_X64 ||
		gain_w == adc_cfg_pkg::GAIN_X32) ? 3'h5 : gain_w;
	assign dgain_w = (gain_w == adc_cfg_pkg::GAIN_X64) ?
		adc_cfg_pkg::DGAIN_X4 :
		(gain_w == adc_cfg_pkg::GAIN_X32) ? adc_cfg_pkg::DGAIN_X2 :
		adc_cfg_pkg::DGAIN_X1;
	assign chop_w = cfg_b_r[adc_cfg_pkg::REFERENCE_CHOP_ENABLE_BIT] & i_ref_internal_sel;
	assign rdata_nxt = sel_a ? cfg_a_r : (sel_b ? cfg_b_r : 8'h00);

	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			cfg_a_r <= adc_cfg_pkg::RST_CFG_A;
			cfg_b_r <= adc_cfg_pkg::RST_CFG_B;
		end
		else if (i_reg_wr & sel_a)
			cfg_a_r <= i_reg_wdata;
		else if (i_reg_wr & sel_b)
			cfg_b_r <= i_reg_wdata;
	end

	// Registered outputs, one cycle behind register state
	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_reg_rdata             <= 8'h00;
			o_analog_clk_div_log2   <= adc_cfg_pkg::RST_CFG_A[7:6];
			o_oversampling_ratio    <= adc_cfg_pkg::RST_CFG_A[5:2];
			o_bias_current_select   <= adc_cfg_pkg::RST_CFG_B[7:6];
			o_analog_gain_code      <= adc_cfg_pkg::RST_CFG_B[5:3];
			o_digital_gain_shift    <= 2'h0;
			o_input_autozero_enable <= 1'h0;
			o_reference_chop_active <= 1'h0;
			o_conv_time_double      <= 1'h0;
			o_single_shot_chain     <= 1'h0;
		end
		else
		begin
			o_reg_rdata <= rdata_nxt;
			o_analog_clk_div_log2 <=
				cfg_a_r[adc_cfg_pkg::PRE_HI:adc_cfg_pkg::PRE_LO];
			o_oversampling_ratio <=
				cfg_a_r[adc_cfg_pkg::OSR_HI:adc_cfg_pkg::OSR_LO];
			o_bias_current_select <=
				cfg_b_r[adc_cfg_pkg::BIAS_HI:adc_cfg_pkg::BIAS_LO];
			o_analog_gain_code   <= again_w;
			o_digital_gain_shift <= dgain_w;
			o_input_autozero_enable <= az_in_w;
			o_reference_chop_active <= chop_w;
			o_conv_time_double <= az_in_w;
			o_single_shot_chain <= az_in_w & i_continuous_req;
		end
	end

	a_gain_x64_split: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) gain_w == 3'h7 |=> o_digital_gain_shift ==
		2'h2 && o_analog_gain_code == 3'h5)
		else $error("gain 111 split wrong");
	a_gain_x32_split: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) gain_w == 3'h6 |=> o_digital_gain_shift ==
		2'h1 && o_analog_gain_code == 3'h5)
		else $error("gain 110 split wrong");
	a_gain_low_pass: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) gain_w < 3'h6 |=> o_digital_gain_shift ==
		2'h0 && o_analog_gain_code == $past(gain_w))
		else $error("low gain code altered");
	a_cfg_a_write: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) i_reg_wr && i_reg_addr == 4'h2 ##1
		!i_reg_wr && i_reg_addr == 4'h2 |=> o_reg_rdata ==
		$past(i_reg_wdata, 2))
		else $error("config A readback wrong");
	a_cfg_b_write: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) i_reg_wr && i_reg_addr == 4'h3 ##1
		!i_reg_wr && i_reg_addr == 4'h3 |=> o_reg_rdata ==
		$past(i_reg_wdata, 2))
		else $error("config B readback wrong");
	a_chop_ext_ref: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) !i_ref_internal_sel |=>
		!o_reference_chop_active)
		else $error("chop active on external ref");
	a_conv_double: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) 1'b1 |=> o_conv_time_double ==
		$past(cfg_b_r[2]))
		else $error("conversion time flag wrong");
	a_single_chain: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) cfg_b_r[2] && i_continuous_req |=>
		o_single_shot_chain)
		else $error("continuous not replaced");
	a_prescale_out: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) $rose(i_reg_wr) && i_reg_addr == 4'h2
		##1 !i_reg_wr [*2] |-> o_analog_clk_div_log2 ==
		$past(i_reg_wdata[7:6], 2))
		else $error("prescaler not exported");

	a_osr_export: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) 1'b1 |=> o_oversampling_ratio ==
		$past(cfg_a_r[5:2]))
		else $error("oversampling not exported");
	a_bias_export: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) 1'b1 |=> o_bias_current_select ==
		$past(cfg_b_r[7:6]))
		else $error("bias not exported");
	a_azin_export: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) 1'b1 |=> o_input_autozero_enable ==
		$past(cfg_b_r[2]))
		else $error("input autozero not exported");
	a_div_export: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) 1'b1 |=> o_analog_clk_div_log2 ==
		$past(cfg_a_r[7:6]))
		else $error("divider not exported");
	a_chop_int_ref: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) i_ref_internal_sel && cfg_b_r[1] |=>
		o_reference_chop_active)
		else $error("chop missing on internal ref");
	a_chop_off: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) !cfg_b_r[1] |=>
		!o_reference_chop_active)
		else $error("chop active while disabled");
	a_chain_off: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) !cfg_b_r[2] |=>
		!o_single_shot_chain)
		else $error("single shots without autozero");
	a_chain_no_cont: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) !i_continuous_req |=>
		!o_single_shot_chain)
		else $error("single shots without request");
	a_conv_single: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) !cfg_b_r[2] |=>
		!o_conv_time_double)
		else $error("time doubled without autozero");
	a_read_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) i_reg_addr == 4'h2 |=>
		o_reg_rdata == $past(cfg_a_r))
		else $error("config A read wrong");
	a_read_b: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) i_reg_addr == 4'h3 |=>
		o_reg_rdata == $past(cfg_b_r))
		else $error("config B read wrong");
	a_read_unmapped: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) i_reg_addr != 4'h2 && i_reg_addr != 4'h3
		|=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_write_a_lands: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) i_reg_wr && i_reg_addr == 4'h2 |=>
		cfg_a_r == $past(i_reg_wdata))
		else $error("config A write lost");
	a_write_b_lands: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) i_reg_wr && i_reg_addr == 4'h3 |=>
		cfg_b_r == $past(i_reg_wdata))
		else $error("config B write lost");
	a_hold_a: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) !(i_reg_wr && i_reg_addr == 4'h2) |=>
		cfg_a_r == $past(cfg_a_r))
		else $error("config A changed unasked");
	a_hold_b: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) !(i_reg_wr && i_reg_addr == 4'h3) |=>
		cfg_b_r == $past(cfg_b_r))
		else $error("config B changed unasked");
	a_gain_cap: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) 1'b1 |=>
		o_analog_gain_code <= 3'h5)
		else $error("analog gain above x16");
	a_gain_unity: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) gain_w == 3'h1 |=> o_analog_gain_code ==
		3'h1 && o_digital_gain_shift == 2'h0)
		else $error("unity gain wrong");
	a_gain_third: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) gain_w == 3'h0 |=> o_analog_gain_code ==
		3'h0 && o_digital_gain_shift == 2'h0)
		else $error("one third gain wrong");
	a_gain_x16: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) gain_w == 3'h5 |=> o_analog_gain_code ==
		3'h5 && o_digital_gain_shift == 2'h0)
		else $error("x16 gain wrong");
	a_shift_x4_only: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) o_digital_gain_shift == 2'h2 |->
		$past(gain_w) == 3'h7)
		else $error("x4 shift without code 111");
	a_shift_x2_only: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) o_digital_gain_shift == 2'h1 |->
		$past(gain_w) == 3'h6)
		else $error("x2 shift without code 110");
	a_rst_bias: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) $past(i_sys_rst) |->
		cfg_b_r[7:6] == 2'h2)
		else $error("bias reset value wrong");
	a_rst_gain: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) $past(i_sys_rst) |->
		cfg_b_r[5:3] == 3'h1)
		else $error("gain reset value wrong");
	a_rst_autozero: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) $past(i_sys_rst) |->
		!cfg_b_r[2])
		else $error("input autozero reset wrong");
	a_rst_ref_chop: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) $past(i_sys_rst) |->
		cfg_b_r[1])
		else $error("reference chop reset wrong");
	a_rst_prescale: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) $past(i_sys_rst) |->
		cfg_a_r[7:6] == 2'h0)
		else $error("prescaler reset wrong");
	a_rst_osr: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) $past(i_sys_rst) |->
		cfg_a_r[5:2] == 4'h3)
		else $error("oversampling reset wrong");
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        i_clk_sys, i_sys_rst, i_reg_wr;
	logic        i_ref_internal_sel, i_continuous_req;
	logic [3:0]  i_reg_addr;
	logic [7:0]  i_reg_wdata, o_reg_rdata, va, vb;
	logic [1:0]  o_analog_clk_div_log2, o_bias_current_select;
	logic [3:0]  o_oversampling_ratio;
	logic [2:0]  o_analog_gain_code;
	logic [1:0]  o_digital_gain_shift;
	logic        o_input_autozero_enable, o_reference_chop_active;
	logic        o_conv_time_double, o_single_shot_chain;
	logic [31:0] seed;
	logic [17:0] outs;
	int          error_cnt, compares;
	adc_conversion_config_regs u_dut (.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
		.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
		.i_ref_internal_sel(i_ref_internal_sel),
		.i_continuous_req(i_continuous_req),
		.o_analog_clk_div_log2(o_analog_clk_div_log2),
		.o_oversampling_ratio(o_oversampling_ratio),
		.o_bias_current_select(o_bias_current_select),
		.o_analog_gain_code(o_analog_gain_code),
		.o_digital_gain_shift(o_digital_gain_shift),
		.o_input_autozero_enable(o_input_autozero_enable),
		.o_reference_chop_active(o_reference_chop_active),
		.o_conv_time_double(o_conv_time_double),
		.o_single_shot_chain(o_single_shot_chain));
	assign outs = {o_analog_clk_div_log2, o_oversampling_ratio,
		o_bias_current_select, o_analog_gain_code, o_digital_gain_shift,
		o_input_autozero_enable, o_reference_chop_active,
		o_conv_time_double, o_single_shot_chain};
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Codes above x16 keep the analog stage at x16
	function automatic logic [17:0] exp_out(input logic [7:0] a, b,
		input logic rs, cr);
		logic [2:0] g;
		g = b[5:3];
		return {a[7:2], b[7:6], (g > 3'h5) ? 3'h5 : g,
			(g == 3'h7) ? 2'h2 : (g == 3'h6) ? 2'h1 : 2'h0,
			b[2], b[1] & rs, b[2], b[2] & cr};
	endfunction
	task automatic finish_test;
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [17:0] e, g);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_reg_addr  <= a;
		i_reg_wr    <= 1'b1;
		i_reg_wdata <= d;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
		@(posedge i_clk_sys);
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		@(posedge i_clk_sys);
		#1;
		chk({10'h0, e}, {10'h0, o_reg_rdata});
	endtask
	initial
	begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	initial
	begin
		{i_reg_addr, i_reg_wr, i_reg_wdata, i_continuous_req} = '0;
		i_sys_rst = 1'b1;
		i_ref_internal_sel = 1'b1;
		seed = 32'h01a4;
		repeat (2) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		rd(4'h2, 8'h0c);
		rd(4'h3, 8'h8b);
		chk(exp_out(8'h0c, 8'h8b, 1'b1, 1'b0), outs);
		$display("reset values done");
		for (int i = 0; i < 40; i++)
		begin
			seed = lfsr(seed);
			// Reserved bits kept as software must keep them
			va = {seed[7:2], 2'h0};
			vb = {seed[15:9], 1'b1};
			if (i < 8)
				vb[5:3] = i[2:0];
			i_ref_internal_sel <= seed[16];
			i_continuous_req   <= seed[17];
			wr(4'h2, va);
			chk({10'h0, va}, {10'h0, o_reg_rdata});
			wr(4'h3, vb);
			chk({10'h0, vb}, {10'h0, o_reg_rdata});
			chk(exp_out(va, vb, seed[16], seed[17]), outs);
		end
		$display("random writes done");
		wr(4'h5, 8'h5a);
		chk(18'h0, {10'h0, o_reg_rdata});
		chk(exp_out(va, vb, seed[16], seed[17]), outs);
		rd(4'h2, va);
		@(posedge i_clk_sys);
		i_sys_rst <= 1'b1;
		@(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		rd(4'h3, 8'h8b);
		$display("unmapped and second reset done");
		finish_test();
	end
	initial
	begin
		#200000;
		error_cnt++;
		finish_test();
	end
endmodule
`default_nettype wire
